// ===== src/srxl_pkg.sv
// Summary of operation
// [RULE1] Characters carry 8 data bits, or 9 with word-9 set; bit 9 lands in control one.
// [RULE2] Serial bits arrive and shift in least significant bit first.
// [RULE3] Setting receiver enable starts the hunt for a start bit.
// [RULE4] A finished character moves to the receive buffer and sets receive-full.
// [RULE5] Software clears receive-full by status access then data read, before next character.
// [RULE6] Idle line acts like a received character, interrupting when idle enable is set.
// [RULE7] Character done while full sets overrun, buffer kept, receive interrupt if enabled.
// [RULE8] Overrun clears only by status access followed by data read.
// [RULE9] Noise sets noise flag with receive-full, data still stored, no own interrupt.
// [RULE10] Noise flag clears by status access then data read.
// [RULE11] Missing stop bit or break sets framing flag, data still stored.
// [RULE12] Framing flag clears by status access then data read.
// [RULE13] Break reads as framing error with data zero.
// [RULE14] Wait mode changes nothing; any interrupt requests wake-up.
// [RULE15] Halt freezes registers and reception; no wake-up from halt.
// [RULE16] All events share one interrupt line, each paired with its enable.
// [RULE17] An event interrupts only when its enable is set and CPU mask clear.
// [RULE18] Invalid header sets header error and receive interrupt when enabled.
// [RULE19] With auto-resync a header error may block; clear blocked flag, then header error.
// [RULE20] Header error clears by status access then data read.
// [RULE21] Without auto-resync a synch field other than 55h sets header error.
// [RULE22] With monitoring, header not done within 57 bit times after break is an error.
// [RULE23] Data read without prior status access leaves the flags set.
// [RULE24] Reset clears enable, flags and blocked flag; receiver stays idle.
package srxl_pkg;
  localparam logic [7:0]  ADDR_STATUS = 8'h00;
  localparam logic [7:0]  ADDR_DATA   = 8'h04;
  localparam logic [7:0]  ADDR_CTRL   = 8'h08;
  localparam logic [7:0]  ADDR_BAUD   = 8'h0C;
  localparam int          ST_RX_FULL  = 0;
  localparam int          ST_IDLE     = 1;
  localparam int          ST_OVERRUN  = 2;
  localparam int          ST_NOISE    = 3;
  localparam int          ST_FRAMING  = 4;
  localparam int          ST_HDR_ERR  = 5;
  localparam int          ST_HDR_DET  = 6;
  localparam int          ST_BLOCKED  = 7;
  localparam int          CT_RX_EN    = 0;
  localparam int          CT_WORD9    = 1;
  localparam int          CT_RX_IE    = 2;
  localparam int          CT_IDLE_IE  = 3;
  localparam int          CT_HDR_IE   = 4;
  localparam int          CT_RESYNC   = 5;
  localparam int          CT_HDR_MTH  = 6;
  localparam int          CT_LIN      = 7;
  localparam int          CT_NINTH    = 8;
  localparam int          CTRL_W      = 8;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] BAUD_RESET  = 16'h0000;
  localparam logic [3:0]  SMP_A       = 4'h7;
  localparam logic [3:0]  SMP_B       = 4'h8;
  localparam logic [3:0]  SMP_C       = 4'h9;
  localparam logic [3:0]  SMP_LAST    = 4'hF;
  localparam logic [3:0]  BITS_8      = 4'h8;
  localparam logic [3:0]  BITS_9      = 4'h9;
  localparam logic [7:0]  LIN_SYNC    = 8'h55;
  localparam logic [7:0]  BREAK_VALUE = 8'h00;
  localparam int          OVERSAMPLE  = 16;
  localparam int          HDR_BITS    = 57;
  localparam int          HDR_SAMPLES = HDR_BITS * OVERSAMPLE;
  localparam logic [9:0]  HDR_LIMIT   = 10'(HDR_SAMPLES - 1);
  localparam logic [7:0]  FRAME10_SMP = 8'(10 * OVERSAMPLE - 1);
  localparam logic [7:0]  FRAME11_SMP = 8'(11 * OVERSAMPLE - 1);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} srxl_state_t;
  typedef enum {HP_NONE, HP_SYNC, HP_IDENT} srxl_hdr_t;
endpackage

// ===== src/srxl_top.sv
`timescale 1ns/1ps
module srxl_top
  import srxl_pkg::*;
#(
  parameter int BAUD_W = 16
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SERIAL_IN_PIN,
  input  wire logic        CPU_IRQ_MASK,
  input  wire logic        WAIT_MODE,
  input  wire logic        HALT_MODE,
  output logic             IRQ,
  output logic             WAKE_REQ
);
  logic              pin_meta_reg;
  logic              pin_reg;
  logic              pready_reg;
  logic              slverr_reg;
  logic [31:0]       prdata_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [BAUD_W-1:0] div_cnt_reg;
  logic              tick;
  srxl_state_t       state_reg;
  logic [3:0]        smp_cnt_reg;
  logic [3:0]        bit_cnt_reg;
  logic [1:0]        vote_reg;
  logic [8:0]        shift_reg;
  logic              noisy_reg;
  logic              vote;
  logic              unanimous;
  logic              frame_done;
  logic [7:0]        rx_byte;
  logic              rx_ninth;
  logic              is_break;
  logic [7:0]        rx_buf_reg;
  logic              ninth_rx_bit_reg;
  logic              rx_full_reg;
  logic              idle_reg;
  logic              overrun_reg;
  logic              noise_reg;
  logic              framing_reg;
  logic              hdr_err_reg;
  logic              hdr_det_reg;
  logic              blocked_reg;
  logic              status_seen_reg;
  logic [7:0]        idle_cnt_reg;
  logic              idle_armed_reg;
  logic              idle_event;
  srxl_hdr_t         hdr_phase_reg;
  logic [9:0]        hdr_cnt_reg;
  logic              hdr_timeout;
  logic              sync_bad;
  logic              hdr_err_event;
  logic              block_event;
  logic              run;
  logic              xfer;
  logic              status_acc;
  logic              data_read;
  logic              clear_seq;
  logic              blocked_clr;
  logic              rx_live;
  logic [31:0]       rd_mux;
  logic              unmapped;
  logic              irq_next;

  assign run         = !HALT_MODE;
  assign xfer        = PSEL && PENABLE && pready_reg;
  assign status_acc  = xfer && (PADDR == ADDR_STATUS);
  assign data_read   = xfer && !PWRITE && (PADDR == ADDR_DATA);
  assign clear_seq   = data_read && status_seen_reg;   // [RULE23]
  assign blocked_clr = status_acc && PWRITE && PWDATA[ST_BLOCKED];
  assign rx_live     = ctrl_reg[CT_RX_EN] && !blocked_reg;
  assign unmapped    = (PADDR != ADDR_STATUS) && (PADDR != ADDR_DATA) &&
                       (PADDR != ADDR_CTRL) && (PADDR != ADDR_BAUD);

  // Pin crosses in from outside: two flops before any logic
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta_reg <= 1'b1;
      pin_reg      <= 1'b1;
    end else begin
      pin_meta_reg <= SERIAL_IN_PIN;
      pin_reg      <= pin_meta_reg;
    end
  end

  // Bus answers with one wait state so decode and read data come from flops
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_reg <= 1'b0;
      slverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= PSEL && PENABLE && !pready_reg;
      slverr_reg <= PSEL && PENABLE && !pready_reg && unmapped;
      if (PSEL && PENABLE && !pready_reg && !PWRITE) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (PADDR == ADDR_STATUS) begin
      rd_mux[ST_RX_FULL] = rx_full_reg;
      rd_mux[ST_IDLE]    = idle_reg;
      rd_mux[ST_OVERRUN] = overrun_reg;
      rd_mux[ST_NOISE]   = noise_reg;
      rd_mux[ST_FRAMING] = framing_reg;
      rd_mux[ST_HDR_ERR] = hdr_err_reg;
      rd_mux[ST_HDR_DET] = hdr_det_reg;
      rd_mux[ST_BLOCKED] = blocked_reg;
    end else if (PADDR == ADDR_DATA) begin
      rd_mux[7:0] = rx_buf_reg;
    end else if (PADDR == ADDR_CTRL) begin
      rd_mux[CTRL_W-1:0] = ctrl_reg;
      rd_mux[CT_NINTH]   = ninth_rx_bit_reg;
    end else if (PADDR == ADDR_BAUD) begin
      rd_mux[BAUD_W-1:0] = baud_reg;
    end
  end

  // Halt freezes software writes as well
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= CTRL_RESET;                           // [RULE24]
      baud_reg <= BAUD_RESET;
    end else if (run && xfer && PWRITE) begin           // [RULE15]
      if (PADDR == ADDR_CTRL) begin
        ctrl_reg <= PWDATA[CTRL_W-1:0];                 // [RULE3]
      end else if (PADDR == ADDR_BAUD) begin
        baud_reg <= PWDATA[BAUD_W-1:0];
      end
    end
  end

  // Baud divider gives one tick per sixteenth of a bit
  assign tick = run && (div_cnt_reg == '0);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt_reg <= '0;
    end else if (run) begin
      div_cnt_reg <= tick ? baud_reg : div_cnt_reg - 1'b1;
    end
  end

  // Majority of three mid-bit samples; disagreement means noise
  assign vote      = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & pin_reg) |
                     (vote_reg[1] & pin_reg);
  assign unanimous = (vote_reg[0] == pin_reg) && (vote_reg[1] == pin_reg);
  assign frame_done = tick && (state_reg == RX_STOP) && (smp_cnt_reg == SMP_C);
  assign rx_byte  = ctrl_reg[CT_WORD9] ? shift_reg[7:0] : shift_reg[8:1];   // [RULE1]
  assign rx_ninth = ctrl_reg[CT_WORD9] && shift_reg[8];
  assign is_break = !vote && (rx_byte == BREAK_VALUE) && !rx_ninth;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg   <= RX_IDLE;                           // [RULE24]
      smp_cnt_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
      vote_reg    <= 2'b11;
      shift_reg   <= 9'h000;
      noisy_reg   <= 1'b0;
    end else if (!rx_live) begin
      state_reg <= RX_IDLE;
    end else if (tick) begin                            // [RULE15]
      smp_cnt_reg <= smp_cnt_reg + 1'b1;
      if (smp_cnt_reg == SMP_A) begin
        vote_reg[0] <= pin_reg;
      end
      if (smp_cnt_reg == SMP_B) begin
        vote_reg[1] <= pin_reg;
      end
      case (state_reg)
        RX_IDLE: begin
          smp_cnt_reg <= 4'h0;
          if (!pin_reg) begin                           // [RULE3]
            state_reg <= RX_START;
            noisy_reg <= 1'b0;
          end
        end
        RX_START: begin
          if (smp_cnt_reg == SMP_C) begin
            noisy_reg <= !unanimous;
            if (vote) begin
              state_reg <= RX_IDLE;
            end
          end else if (smp_cnt_reg == SMP_LAST) begin
            state_reg   <= RX_DATA;
            bit_cnt_reg <= 4'h0;
          end
        end
        RX_DATA: begin
          if (smp_cnt_reg == SMP_C) begin
            shift_reg <= {vote, shift_reg[8:1]};        // [RULE2]
            noisy_reg <= noisy_reg | !unanimous;        // [RULE9]
          end else if (smp_cnt_reg == SMP_LAST) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == (ctrl_reg[CT_WORD9] ? BITS_9 : BITS_8) - 1'b1) begin
              state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (smp_cnt_reg == SMP_C) begin
            state_reg <= RX_IDLE;
          end
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

  // Idle: one whole frame time of high line after a character
  assign idle_event = tick && idle_armed_reg && (state_reg == RX_IDLE) && pin_reg &&
                      (idle_cnt_reg == (ctrl_reg[CT_WORD9] ? FRAME11_SMP : FRAME10_SMP));
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_cnt_reg   <= 8'h00;
      idle_armed_reg <= 1'b0;
    end else if (run) begin
      if (frame_done) begin
        idle_armed_reg <= 1'b1;
        idle_cnt_reg   <= 8'h00;
      end else if (idle_event) begin
        idle_armed_reg <= 1'b0;
      end else if (tick) begin
        idle_cnt_reg <= (state_reg == RX_IDLE && pin_reg) ? idle_cnt_reg + 1'b1 : 8'h00;
      end
    end
  end

  // Header tracking: break, synch field, identifier
  assign sync_bad    = frame_done && (hdr_phase_reg == HP_SYNC) && (rx_byte != LIN_SYNC);
  assign hdr_timeout = tick && (hdr_phase_reg != HP_NONE) && (hdr_cnt_reg == HDR_LIMIT) &&
                       (ctrl_reg[CT_HDR_MTH] || ctrl_reg[CT_RESYNC]);         // [RULE22]
  assign hdr_err_event = sync_bad || hdr_timeout;                             // [RULE21]
  // Synch compare stands in for the deviation check when resync is on
  assign block_event = ctrl_reg[CT_RESYNC] && (sync_bad ||
                       (hdr_timeout && hdr_phase_reg == HP_SYNC));            // [RULE19]
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      hdr_phase_reg <= HP_NONE;
      hdr_cnt_reg   <= 10'h000;
    end else if (run) begin
      if (tick && hdr_phase_reg != HP_NONE) begin
        hdr_cnt_reg <= hdr_cnt_reg + 1'b1;
      end
      if (frame_done && ctrl_reg[CT_LIN] && is_break) begin
        hdr_phase_reg <= HP_SYNC;
        hdr_cnt_reg   <= 10'h000;
      end else if (hdr_err_event || blocked_clr) begin
        hdr_phase_reg <= HP_NONE;
      end else if (frame_done && hdr_phase_reg == HP_SYNC) begin
        hdr_phase_reg <= HP_IDENT;
      end else if (frame_done && hdr_phase_reg == HP_IDENT) begin
        hdr_phase_reg <= HP_NONE;
      end
    end
  end

  // Flags: a set in the same cycle as the clearing read wins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_full_reg      <= 1'b0;                         // [RULE24]
      idle_reg         <= 1'b0;
      overrun_reg      <= 1'b0;
      noise_reg        <= 1'b0;
      framing_reg      <= 1'b0;
      hdr_err_reg      <= 1'b0;
      hdr_det_reg      <= 1'b0;
      blocked_reg      <= 1'b0;
      status_seen_reg  <= 1'b0;
      rx_buf_reg       <= 8'h00;
      ninth_rx_bit_reg <= 1'b0;
    end else if (run) begin
      if (status_acc) begin
        status_seen_reg <= 1'b1;
      end else if (data_read) begin
        status_seen_reg <= 1'b0;
      end
      if (frame_done && !rx_full_reg) begin             // [RULE4]
        rx_buf_reg       <= rx_byte;                    // [RULE13]
        ninth_rx_bit_reg <= rx_ninth;                   // [RULE1]
      end
      rx_full_reg <= frame_done || (rx_full_reg && !clear_seq);               // [RULE5]
      idle_reg    <= idle_event || (idle_reg && !clear_seq);                  // [RULE6]
      overrun_reg <= (frame_done && rx_full_reg) || (overrun_reg && !clear_seq); // [RULE7] [RULE8]
      noise_reg   <= (frame_done && !rx_full_reg && (noisy_reg || !unanimous)) ||
                     (noise_reg && !clear_seq);                               // [RULE10]
      framing_reg <= (frame_done && !rx_full_reg && !vote) ||
                     (framing_reg && !clear_seq);                             // [RULE11] [RULE12]
      hdr_err_reg <= hdr_err_event || (hdr_err_reg && !clear_seq);            // [RULE18] [RULE20]
      hdr_det_reg <= (frame_done && hdr_phase_reg == HP_IDENT) || (hdr_det_reg && !clear_seq);
      blocked_reg <= block_event || (blocked_reg && !blocked_clr);
    end
  end

  // One shared line; halt gates only the wake request, IRQ still follows the frozen flags and the CPU mask
  assign irq_next = !CPU_IRQ_MASK && (                                        // [RULE17]
                    (ctrl_reg[CT_RX_IE] && (rx_full_reg || overrun_reg || hdr_err_reg)) ||
                    (ctrl_reg[CT_IDLE_IE] && idle_reg) ||
                    (ctrl_reg[CT_HDR_IE] && hdr_det_reg));                    // [RULE16]
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ      <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      IRQ      <= irq_next;
      WAKE_REQ <= irq_next && WAIT_MODE && run;                               // [RULE14]
    end
  end

  assign PRDATA  = prdata_reg;
  assign PREADY  = pready_reg;
  assign PSLVERR = slverr_reg;

  a_full_on_done: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE4]
    frame_done |=> rx_full_reg) else $error("receive-full not set after character");
  a_overrun_keep_buf: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE7]
    frame_done && rx_full_reg |=> overrun_reg && $stable(rx_buf_reg))
    else $error("overrun lost or buffer overwritten");
  a_lone_read_keeps: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE23]
    run && data_read && !status_seen_reg && (framing_reg || overrun_reg) |=>
    (framing_reg || !$past(framing_reg)) && (overrun_reg || !$past(overrun_reg)))
    else $error("error flag cleared without status access");
  a_seq_clears_all: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE8] [RULE12]
    run && clear_seq && !frame_done |=> !rx_full_reg && !overrun_reg && !framing_reg)
    else $error("clear sequence left flags set");
  a_mask_blocks_irq: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE17]
    CPU_IRQ_MASK |=> !IRQ) else $error("interrupt raised while masked");
  a_sync_mismatch: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE21]
    run && sync_bad |=> hdr_err_reg && (hdr_phase_reg == HP_NONE))
    else $error("bad synch field not flagged");
  a_halt_freeze: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE15]
    HALT_MODE |=> $stable(rx_buf_reg) && $stable(rx_full_reg) && !WAKE_REQ)
    else $error("state moved during halt");
  a_break_zero: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE13]
    frame_done && is_break && !rx_full_reg |=> framing_reg && rx_buf_reg == BREAK_VALUE)
    else $error("break not reported as zero framing error");
  a_disabled_idle: assert property (@(posedge CLK) disable iff (!RST_B) // [RULE3]
    !ctrl_reg[CT_RX_EN] |=> state_reg == RX_IDLE) else $error("receiver ran while off");
  c_overrun: cover property (@(posedge CLK) disable iff (!RST_B) frame_done && rx_full_reg);
  c_break: cover property (@(posedge CLK) disable iff (!RST_B) frame_done && is_break);
  c_header: cover property (@(posedge CLK) disable iff (!RST_B)
    frame_done && hdr_phase_reg == HP_IDENT);
  c_idle: cover property (@(posedge CLK) disable iff (!RST_B) idle_event);
endmodule

// ===== dv/srxl_remote_tx.sv
`timescale 1ns/1ps
module srxl_remote_tx #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  output logic      line
);
  initial line = 1'h1;
  // Glitch lasts one clock mid-bit, so the majority vote still recovers the bit
  task automatic send(input logic [8:0] d, input int nbits, input logic stop, input bit glitch);
    line <= 1'h0;
    repeat (BIT_CLKS) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line <= d[i];
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (glitch && i == 0) begin
        line <= ~d[i];
        @(posedge clk);
        line <= d[i];
        repeat (BIT_CLKS / 2 - 1) @(posedge clk);
      end else begin
        repeat (BIT_CLKS / 2) @(posedge clk);
      end
    end
    line <= stop;
    repeat (BIT_CLKS) @(posedge clk);
    line <= 1'h1;
    @(posedge clk);
  endtask
endmodule

// ===== dv/srxl_top_tb_top.sv
`timescale 1ns/1ps
module srxl_top_tb_top
  import srxl_pkg::*;
;
  localparam int BT = 16;
  typedef struct packed {
    logic [8:0] d;
    logic       w9;
    logic [7:0] xd;
    logic       xn;
  } srxl_row_t;
  srxl_row_t   rows [5] = '{'{9'h0A5, 1'h0, 8'hA5, 1'h0}, '{9'h15A, 1'h1, 8'h5A, 1'h1},
                            '{9'h001, 1'h0, 8'h01, 1'h0}, '{9'h0C3, 1'h1, 8'hC3, 1'h0},
                            '{9'h180, 1'h0, 8'h80, 1'h0}};
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        irq_mask = 1'h0;
  logic        wait_mode = 1'h0;
  logic        halt_mode = 1'h0;
  logic        irq;
  logic        wake_req;
  logic [31:0] rdat;
  logic        rerr;
  int          errors = 0;
  int          n_tests = 0;

  always #50 clk = ~clk;

  srxl_top #(
    .BAUD_W (16)
  ) dut (
    .CLK           (clk),
    .RST_B         (rst_b),
    .PSEL          (psel),
    .PENABLE       (penable),
    .PWRITE        (pwrite),
    .PADDR         (paddr),
    .PWDATA        (pwdata),
    .PRDATA        (prdata),
    .PREADY        (pready),
    .PSLVERR       (pslverr),
    .SERIAL_IN_PIN (rx_line),
    .CPU_IRQ_MASK  (irq_mask),
    .WAIT_MODE     (wait_mode),
    .HALT_MODE     (halt_mode),
    .IRQ           (irq),
    .WAKE_REQ      (wake_req)
  );

  srxl_remote_tx #(
    .BIT_CLKS (BT)
  ) tx (
    .clk  (clk),
    .line (rx_line)
  );

  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    if (pready !== 1'h1) begin
      errors++;
      wrap_up();
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    rd(a);
    chk(rdat & m, x);
  endtask

  task automatic clr();
    rd(ADDR_STATUS);
    rd(ADDR_DATA);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic lin(input logic [7:0] sync, input bit id);
    tx.send(9'h000, 8, 1'h0, 1'h0);
    tx.send({1'h0, sync}, 8, 1'h1, 1'h0);
    if (id) begin
      tx.send(9'h03A, 8, 1'h1, 1'h0);
    end
  endtask

  initial begin
    cyc(12);
    rst_b <= 1'h1;
    cyc(1);
    rc(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rc(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    rc(ADDR_BAUD, 32'hFFFFFFFF, BAUD_RESET);
    // Small divisor so the divider is back to full rate before the first character
    wr(ADDR_BAUD, 32'h3);
    rc(ADDR_BAUD, 32'hFFFFFFFF, 32'h3);
    wr(ADDR_BAUD, {16'h0, BAUD_RESET});
    rd(8'h10);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    tx.send(9'h0A5, 8, 1'h1, 1'h0);
    rc(ADDR_STATUS, 32'hFD, 32'h0);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {30'h0, rows[i].w9, 1'h1});
      tx.send(rows[i].d, rows[i].w9 ? 9 : 8, 1'h1, 1'h0);
      rc(ADDR_STATUS, 32'hFD, 32'h1);
      rc(ADDR_DATA, 32'hFF, {24'h0, rows[i].xd});
      rc(ADDR_STATUS, 32'hFD, 32'h0);
      if (rows[i].w9) begin
        rc(ADDR_CTRL, 32'h100, {23'h0, rows[i].xn, 8'h00});
      end
    end
    // Spend any pending status mark so the next data read is a lone one
    rd(ADDR_DATA);
    wr(ADDR_CTRL, 32'h5);
    tx.send(9'h011, 8, 1'h1, 1'h0);
    tx.send(9'h022, 8, 1'h1, 1'h0);
    chk({31'h0, irq}, 32'h1);
    irq_mask <= 1'h1;
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    irq_mask <= 1'h0;
    wait_mode <= 1'h1;
    cyc(2);
    chk({30'h0, wake_req, irq}, 32'h3);
    wait_mode <= 1'h0;
    rc(ADDR_DATA, 32'hFF, 32'h11);
    rc(ADDR_STATUS, 32'hFD, 32'h5);
    rc(ADDR_DATA, 32'hFF, 32'h11);
    rc(ADDR_STATUS, 32'hFD, 32'h0);
    tx.send(9'h0F1, 8, 1'h1, 1'h1);
    rc(ADDR_STATUS, 32'hFD, 32'h9);
    rc(ADDR_DATA, 32'hFF, 32'hF1);
    rc(ADDR_STATUS, 32'hFD, 32'h0);
    tx.send(9'h03C, 8, 1'h0, 1'h0);
    rc(ADDR_STATUS, 32'hFD, 32'h11);
    rc(ADDR_DATA, 32'hFF, 32'h3C);
    rc(ADDR_STATUS, 32'hFD, 32'h0);
    tx.send(9'h000, 8, 1'h0, 1'h0);
    rc(ADDR_STATUS, 32'hFD, 32'h11);
    rc(ADDR_DATA, 32'hFF, {24'h0, BREAK_VALUE});
    wr(ADDR_CTRL, 32'h9);
    tx.send(9'h05A, 8, 1'h1, 1'h0);
    clr();
    cyc(12 * BT);
    rc(ADDR_STATUS, 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    clr();
    rc(ADDR_STATUS, 32'hFF, 32'h0);
    halt_mode <= 1'h1;
    cyc(1);
    wr(ADDR_CTRL, 32'h0);
    rc(ADDR_CTRL, 32'hFF, 32'h9);
    tx.send(9'h077, 8, 1'h1, 1'h0);
    halt_mode <= 1'h0;
    cyc(BT);
    rc(ADDR_STATUS, 32'hFD, 32'h0);
    wr(ADDR_CTRL, 32'h85);
    lin(8'h54, 1'h0);
    rc(ADDR_STATUS, 32'hA0, 32'h20);
    chk({31'h0, irq}, 32'h1);
    clr();
    rc(ADDR_STATUS, 32'h20, 32'h0);
    wr(ADDR_CTRL, 32'hA5);
    lin(8'h54, 1'h0);
    rc(ADDR_STATUS, 32'hA0, 32'hA0);
    wr(ADDR_STATUS, 32'h80);
    rd(ADDR_DATA);
    rc(ADDR_STATUS, 32'hA0, 32'h0);
    wr(ADDR_CTRL, 32'hD1);
    lin(8'h55, 1'h1);
    rc(ADDR_STATUS, 32'hE0, 32'h40);
    chk({31'h0, irq}, 32'h1);
    clr();
    tx.send(9'h000, 8, 1'h0, 1'h0);
    clr();
    cyc(50 * BT);
    rc(ADDR_STATUS, 32'hFD, 32'h0);
    cyc(10 * BT);
    rc(ADDR_STATUS, 32'hFD, 32'h20);
    // Only the header error is left to raise the line
    wr(ADDR_CTRL, 32'hD5);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    rst_b <= 1'h0;
    cyc(2);
    rst_b <= 1'h1;
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    rc(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rc(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    wrap_up();
  end
endmodule
